// file: src/adcct_pkg.sv
package adcct_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_TRIG   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TIME   = 8'h0c;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CTRL_RUN     = 0;
    localparam int CTRL_CMPEN   = 1;
    localparam int CTRL_DIV_LO  = 2;
    localparam int CTRL_DIV_HI  = 4;
    localparam int CTRL_SPD_LO  = 5;
    localparam int CTRL_SPD_HI  = 6;
    localparam int CTRL_LOWSPD  = 7;
    localparam int CTRL_WAIT    = 8;
    localparam int CTRL_HWTRIG  = 9;
    localparam int CTRL_SCAN    = 10;
    localparam int CTRL_SEQ     = 11;
    localparam int CTRL_W       = 12;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;

    // Status bit positions
    localparam int STAT_BUSY   = 0;
    localparam int STAT_DONE   = 1;
    localparam int STAT_PROHIB = 2;
    localparam int STAT_CFGERR = 3;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [2:0] DIV_32  = 3'h0;
    localparam logic [2:0] DIV_4   = 3'h3;
    localparam logic [2:0] DIV_1   = 3'h5;
    localparam logic [1:0] SPD_NM1 = 2'h0;
    localparam logic [1:0] SPD_NM2 = 2'h1;

    // ------------------------------------------------------------
    // Cycle counts in conversion-clock cycles
    // ------------------------------------------------------------
    localparam logic [9:0] NM1_SEL_CYC = 10'h042;  // 66
    localparam logic [9:0] NM1_SCN_CYC = 10'h102;  // 258
    localparam logic [9:0] NM2_SEL_CYC = 10'h0b7;  // 183
    localparam logic [9:0] NM2_SCN_CYC = 10'h2d6;  // 726
    localparam logic [9:0] SEQ_SAVE    = 10'h003;  // 3
    // Wait-mode surcharge per divider code, low-speed off / on
    localparam logic [5:0] WAIT_X_FAST [0:5] = '{6'h06, 6'h06, 6'h08, 6'h0c, 6'h14, 6'h24};
    localparam logic [5:0] WAIT_X_SLOW [0:5] = '{6'h00, 6'h00, 6'h00, 6'h06, 6'h06, 6'h08};

    // ------------------------------------------------------------
    // Halt guard time before clock or speed fields may change
    // ------------------------------------------------------------
    localparam real CLK_MHZ      = 250.0;
    localparam real HALT_GUARD_US = 0.2;
    localparam int  HALT_GUARD_CYC = int'($ceil(HALT_GUARD_US * CLK_MHZ));

    typedef enum logic [1:0] {
        ADCCT_IDLE,
        ADCCT_START,
        ADCCT_SETTLE,
        ADCCT_CONV
    } adcct_state_t;
endpackage

// file: src/adcct_clock_div.sv
`timescale 1ns/1ns
// Conversion clock enable from the bus clock, divided by 32..1
module adcct_clock_div
    import adcct_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstSync_n,
    // Control
    input  wire logic       enable,
    input  wire logic [2:0] divSel,
    // Output
    output logic            tick
);
    logic [4:0] count;
    logic [4:0] limit;

    // Terminal count: 000b divides by 32, 101b passes the clock through
    assign limit = 5'(5'h1f >> divSel);

    // Counter restarts while idle so every frame starts phase-aligned
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            count <= 5'h00;
            tick  <= 1'b0;
        end else if (!enable) begin
            count <= 5'h00;
            tick  <= 1'b0;
        end else begin
            tick  <= (count >= limit);
            count <= (count >= limit) ? 5'h00 : 5'(count + 5'h01);
        end
    end
endmodule

// file: src/adc_conversion_timing_control.sv
`timescale 1ns/1ns
//
// Overview of operation
// - Duration sums start, settle and convert phases
// - Software and hardware triggers share timing
// - Wait mode adds settle on first conversion only
// - Normal mode 2 counts 183/189+/726
// - Sequential conversion saves three cycles
// - First conversion adds start time
// - Normal mode 1 counts 66/258
module adc_conversion_timing_control
    import adcct_pkg::*;
#(
    parameter logic [3:0] START_CYC = 4'h2
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Hardware trigger
    input  wire logic        hwTrigger,
    // Converter status
    output logic             convBusy,
    output logic             convDone
);
    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rstMeta_n;
    logic rstSync_n;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;
    adcct_state_t      state;
    logic [9:0]        phaseCount;
    logic [11:0]       elapsed;
    logic [11:0]       lastTime;
    logic              firstConv;
    logic              doneFlag;
    logic              prohibFlag;
    logic              cfgErrFlag;
    logic [7:0]        haltTimer;
    logic              tick;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire accessEnd  = psel && penable && pready;
    wire isCtrl     = (paddr == ADDR_CTRL);
    wire isTrig     = (paddr == ADDR_TRIG);
    wire isStatus   = (paddr == ADDR_STATUS);
    wire isTime     = (paddr == ADDR_TIME);
    wire mapped     = isCtrl || isTrig || isStatus || isTime;
    wire wrCtrl     = accessEnd && pwrite && isCtrl;
    wire wrTrig     = accessEnd && pwrite && isTrig && pwdata[0];
    wire wrStatus   = accessEnd && pwrite && isStatus;

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    wire       runBit    = ctrl[CTRL_RUN];
    wire       cmpEnBit  = ctrl[CTRL_CMPEN];
    wire [2:0] divSel    = ctrl[CTRL_DIV_HI:CTRL_DIV_LO];
    wire [1:0] speedSel  = ctrl[CTRL_SPD_HI:CTRL_SPD_LO];
    wire       lowSpeed  = ctrl[CTRL_LOWSPD];
    wire       waitMode  = ctrl[CTRL_WAIT];
    wire       hwMode    = ctrl[CTRL_HWTRIG];
    wire       scanMode  = ctrl[CTRL_SCAN];
    wire       seqMode   = ctrl[CTRL_SEQ];

    wire halted   = !runBit && !cmpEnBit;
    wire guardOk  = halted && (haltTimer == 8'(HALT_GUARD_CYC));
    wire [CTRL_W-1:0] wrVal = pwdata[CTRL_W-1:0];
    wire cfgChange = (wrVal[CTRL_LOWSPD:CTRL_DIV_LO] != ctrl[CTRL_LOWSPD:CTRL_DIV_LO]);
    wire cfgReject = wrCtrl && cfgChange && !guardOk;
    // Rejected writes keep the old clock and speed fields; other bits still land
    wire [CTRL_W-1:0] next_ctrl = cfgReject ?
        {wrVal[CTRL_W-1:CTRL_LOWSPD+1], ctrl[CTRL_LOWSPD:CTRL_DIV_LO], wrVal[CTRL_CMPEN:0]} :
        wrVal;

    wire divLegal   = lowSpeed ? (divSel >= DIV_4 && divSel <= DIV_1) : (divSel <= DIV_1);
    // Low-voltage speed modes are not timed by this block
    wire spdLegal   = (speedSel == SPD_NM1) || (speedSel == SPD_NM2);
    wire setupLegal = divLegal && spdLegal;

    // ------------------------------------------------------------
    // Cycle budget per conversion
    // ------------------------------------------------------------
    wire [2:0] divIdx  = divLegal ? divSel : DIV_32;
    wire [5:0] waitX   = lowSpeed ? WAIT_X_SLOW[divIdx] : WAIT_X_FAST[divIdx];
    wire [9:0] baseCyc = (speedSel == SPD_NM2) ?
                         (scanMode ? NM2_SCN_CYC : NM2_SEL_CYC) :
                         (scanMode ? NM1_SCN_CYC : NM1_SEL_CYC);
    wire [9:0] convCyc = seqMode ? 10'(baseCyc - SEQ_SAVE) : baseCyc;
    wire       doSettle = waitMode && firstConv;

    wire trigger  = hwMode ? hwTrigger : wrTrig;
    wire armed    = runBit && cmpEnBit;
    wire lastTick = tick && (phaseCount == 10'h001);
    wire convEnd  = (state == ADCCT_CONV) && lastTick;
    wire repeatOn = seqMode && armed;

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    adcct_clock_div u_div (
        .clock     (clock),
        .rstSync_n (rstSync_n),
        .enable    (state != ADCCT_IDLE),
        .divSel    (divIdx),
        .tick      (tick)
    );

    // Phase walk; a halt aborts the frame at once
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state      <= ADCCT_IDLE;
            phaseCount <= 10'h000;
            firstConv  <= 1'b1;
        end else if (!armed) begin
            state      <= ADCCT_IDLE;
            firstConv  <= 1'b1;
        end else begin
            case (state)
                ADCCT_IDLE: begin
                    if (trigger && setupLegal) begin
                        state      <= firstConv ? ADCCT_START : ADCCT_CONV;
                        phaseCount <= firstConv ? 10'(START_CYC) : convCyc;
                    end
                end
                ADCCT_START: begin
                    if (lastTick) begin
                        state      <= doSettle ? ADCCT_SETTLE : ADCCT_CONV;
                        phaseCount <= doSettle ? 10'(waitX) : convCyc;
                    end else if (tick) begin
                        phaseCount <= 10'(phaseCount - 10'h001);
                    end
                end
                ADCCT_SETTLE: begin
                    if (lastTick) begin
                        state      <= ADCCT_CONV;
                        phaseCount <= convCyc;
                    end else if (tick) begin
                        phaseCount <= 10'(phaseCount - 10'h001);
                    end
                end
                ADCCT_CONV: begin
                    if (lastTick) begin
                        firstConv  <= 1'b0;
                        state      <= repeatOn ? ADCCT_CONV : ADCCT_IDLE;
                        phaseCount <= convCyc;
                    end else if (tick) begin
                        phaseCount <= 10'(phaseCount - 10'h001);
                    end
                end
                default: begin
                    state <= ADCCT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            elapsed  <= 12'h000;
            lastTime <= 12'h000;
        end else if (convEnd) begin
            lastTime <= 12'(elapsed + 12'h001);
            elapsed  <= 12'h000;
        end else if (state == ADCCT_IDLE) begin
            elapsed  <= 12'h000;
        end else if (tick) begin
            elapsed  <= 12'(elapsed + 12'h001);
        end
    end

    // Guard timer runs only while halted, saturating at the guard time
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            haltTimer <= 8'h00;
        end else if (!halted) begin
            haltTimer <= 8'h00;
        end else if (haltTimer != 8'(HALT_GUARD_CYC)) begin
            haltTimer <= 8'(haltTimer + 8'h01);
        end
    end

    // ------------------------------------------------------------
    // Registers and sticky flags (set beats clear)
    // ------------------------------------------------------------
    wire prohibHit = trigger && armed && (state == ADCCT_IDLE) && !setupLegal;

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ctrl       <= CTRL_RESET;
            doneFlag   <= 1'b0;
            prohibFlag <= 1'b0;
            cfgErrFlag <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrl <= next_ctrl;
            end
            doneFlag   <= convEnd   || (doneFlag   && !(wrStatus && pwdata[STAT_DONE]));
            prohibFlag <= prohibHit || (prohibFlag && !(wrStatus && pwdata[STAT_PROHIB]));
            cfgErrFlag <= cfgReject || (cfgErrFlag && !(wrStatus && pwdata[STAT_CFGERR]));
        end
    end

    // ------------------------------------------------------------
    // APB answer: one wait state so read data comes from a flop
    // ------------------------------------------------------------
    wire [31:0] statusWord = {28'h0000000, cfgErrFlag, prohibFlag, doneFlag,
                              (state != ADCCT_IDLE)};
    wire [31:0] readMux = isCtrl   ? {20'h00000, ctrl} :
                          isStatus ? statusWord :
                          isTime   ? {20'h00000, lastTime} : 32'h00000000;

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pready   <= 1'b0;
            prdata   <= 32'h00000000;
            pslverr  <= 1'b0;
            convBusy <= 1'b0;
            convDone <= 1'b0;
        end else begin
            pready   <= psel && penable && !pready;
            prdata   <= (psel && penable && !pready && !pwrite) ? readMux : 32'h00000000;
            pslverr  <= psel && penable && !pready && !mapped;
            convBusy <= (state != ADCCT_IDLE);
            convDone <= convEnd;
        end
    end
endmodule

// file: sim/adcct_asserts.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module adcct_asserts
    import adcct_pkg::*;
#(
    parameter logic [3:0] START_CYC = 4'h2
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Converter
    input wire logic        hwTrigger,
    input wire logic        convBusy,
    input wire logic        convDone
);
    // Shortest frame is 63 ticks, a few clocks lost to capture
    localparam int MIN_CYC = 60;
    logic [15:0] frameCnt;
    logic        mapped;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // Four mapped words
    assign mapped = paddr inside {ADDR_CTRL, ADDR_TRIG, ADDR_STATUS, ADDR_TIME};
    // Busy clocks since frame start or last done
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            frameCnt <= 16'h0000;
        end else if (convDone || !convBusy) begin
            frameCnt <= 16'h0000;
        end else begin
            frameCnt <= frameCnt + 16'h0001;
        end
    end
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    read_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero while idle");
    unmapped_err_a: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match decode");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer carries data");
    done_pulse_a: assert property (convDone |=> !convDone)
        else $error("convDone longer than one cycle");
    done_frame_a: assert property (convDone |-> $past(convBusy))
        else $error("convDone without a frame");
    frame_length_a: assert property (convDone |-> frameCnt >= MIN_CYC)
        else $error("frame shorter than any count");
    cover property (convDone);
    cover property (pslverr);
    cover property (hwTrigger ##[1:20] convBusy);
endmodule
bind adc_conversion_timing_control adcct_asserts #(.START_CYC(START_CYC)) u_adcct_asserts (
    .clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .hwTrigger, .convBusy, .convDone
);

// file: sim/adcct_trig_source.sv
`timescale 1ns/1ns
// ----------------------------------------
// Hardware trigger source
// ----------------------------------------
module adcct_trig_source (
    // Clock
    input  wire logic       clock,
    // Request from the bench
    input  wire logic       fire,
    input  wire logic [3:0] lag,
    // Trigger line
    output logic            hwTrigger
);
    logic [4:0] count = 5'h00;
    initial hwTrigger = 1'b0;
    // one pulse after lag
    // Lag lets the source answer promptly or late
    always @(posedge clock) begin
        if (fire) begin
            count <= {1'b0, lag} + 5'h01;
        end else if (count != 5'h00) begin
            count <= count - 5'h01;
        end
        hwTrigger <= (count == 5'h01) && !fire;
    end
endmodule

// file: sim/adc_conversion_timing_control_tb_top.sv
`timescale 1ns/1ns
module adc_conversion_timing_control_tb_top;
    import adcct_pkg::*;
    typedef struct {logic [11:0] cfg; logic [11:0] t1; logic [11:0] t2;} adcct_row_t;
    logic        clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic        fire = 1'b0, pready, pslverr, hwTrigger, convBusy, convDone;
    logic [3:0]  lag = 4'h0;
    logic [11:0] cur = 12'h000;
    logic [11:0] bad [2] = '{12'h0a0, 12'h074};
    int          errors = 0, checkCount = 0, doneCount = 0;
    // Setup without run bits, first TIME, repeat TIME; start delay is 2 ticks
    adcct_row_t rows [17] = '{'{12'h034, 12'h0b9, 12'h0}, '{12'h434, 12'h2d8, 12'h0},
        '{12'h014, 12'h044, 12'h0}, '{12'h414, 12'h104, 12'h0}, '{12'h134, 12'h0dd, 12'h0},
        '{12'h1b4, 12'h0c1, 12'h0}, '{12'h1ac, 12'h0bf, 12'h0}, '{12'h1b0, 12'h0bf, 12'h0},
        '{12'h120, 12'h0bf, 12'h0}, '{12'h124, 12'h0bf, 12'h0}, '{12'h128, 12'h0c1, 12'h0},
        '{12'h12c, 12'h0c5, 12'h0}, '{12'h130, 12'h0cd, 12'h0}, '{12'h234, 12'h0b9, 12'h0},
        '{12'h334, 12'h0dd, 12'h0}, '{12'h834, 12'h0b6, 12'h0b4}, '{12'h934, 12'h0da, 12'h0b4}};
    always #2 clock = ~clock;
    always @(posedge clock) if (convDone === 1'b1) doneCount++;
    adc_conversion_timing_control #(.START_CYC(4'h2)) u_adc_conversion_timing_control (
        .clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .hwTrigger, .convBusy, .convDone);
    adcct_trig_source u_adcct_trig_source (.clock, .fire, .lag, .hwTrigger);
    // One APB transfer, request held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 40);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1) errors++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [11:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {20'h0, d}, q, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checkCount++;
        if (g !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic chkIn(input string nm, input int lo, input int hi, input int g);
        checkCount++;
        if (g < lo || g > hi) begin
            errors++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    // Bounded wait for convDone, counting clocks
    task automatic waitDone(output int n);
        n = 0;
        while (convDone !== 1'b1 && n < 30000) begin
            @(posedge clock);
            n++;
        end
        if (n == 30000) errors++;
    endtask
    // Halt, keep the guard time, load fields, arm, clear flags
    task automatic setup(input logic [11:0] c);
        wr(ADDR_CTRL, cur);
        repeat (HALT_GUARD_CYC + 10) @(posedge clock);
        wr(ADDR_CTRL, c);
        wr(ADDR_CTRL, c | 12'h003);
        wr(ADDR_STATUS, 12'h00e);
        cur = c;
    endtask
    task automatic trigger(input logic hw);
        if (hw) begin
            lag <= cur[8] ? 4'h9 : 4'h0;
            fire <= 1'b1;
            @(posedge clock);
            fire <= 1'b0;
        end else begin
            wr(ADDR_TRIG, 12'h001);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Longest path is some 18k clocks
    initial begin
        #200000;
        errors++;
        summarize();
    end
    initial begin
        int n, dv, k;
        logic e;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        rd(ADDR_CTRL, rdata);
        chk("ctrl reset", {20'h0, CTRL_RESET}, rdata);
        rd(ADDR_STATUS, rdata);
        chk("status reset", 32'h0, rdata);
        $display("reset values done");
        foreach (rows[i]) begin
            setup(rows[i].cfg);
            if (rows[i].cfg[CTRL_HWTRIG]) begin
                wr(ADDR_TRIG, 12'h001);
                repeat (4) @(posedge clock);
                chk("sw trig in hw mode", 32'h0, {31'h0, convBusy});
            end
            trigger(rows[i].cfg[CTRL_HWTRIG]);
            waitDone(n);
            rd(ADDR_TIME, rdata);
            chk("first time", {20'h0, rows[i].t1}, rdata);
            dv = 32 >> rows[i].cfg[4:2];
            chkIn("clocks", rows[i].t1 * dv, rows[i].t1 * dv + dv + 16, n);
            if (rows[i].t2 !== 12'h000) begin
                waitDone(n);
                rd(ADDR_TIME, rdata);
                chk("repeat time", {20'h0, rows[i].t2}, rdata);
            end
            $display("row %0d done", i);
        end
        apb(1'b0, 8'h10, 32'h0, rdata, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, rdata);
        $display("unmapped test done");
        // Divider change while the sequential run goes on
        wr(ADDR_CTRL, cur ^ 12'h004 | 12'h003);
        rd(ADDR_CTRL, rdata);
        chk("ctrl kept", {20'h0, cur | 12'h003}, rdata);
        rd(ADDR_STATUS, rdata);
        chk("cfg reject", 32'h1, {31'h0, rdata[STAT_CFGERR]});
        wr(ADDR_CTRL, cur);
        // A done launched at the halting edge itself is still legal
        repeat (2) @(posedge clock);
        k = doneCount;
        repeat (300) @(posedge clock);
        chk("abort no done", 32'(k), 32'(doneCount));
        $display("refuse and abort done");
        wr(ADDR_CTRL, cur | 12'h003);
        wr(ADDR_CTRL, cur);
        wr(ADDR_CTRL, cur ^ 12'h004);
        rd(ADDR_CTRL, rdata);
        chk("guard kept", {20'h0, cur}, rdata);
        repeat (HALT_GUARD_CYC) @(posedge clock);
        wr(ADDR_CTRL, cur ^ 12'h004);
        rd(ADDR_CTRL, rdata);
        chk("guard over", {20'h0, cur ^ 12'h004}, rdata);
        cur = cur ^ 12'h004;
        $display("guard test done");
        foreach (bad[j]) begin
            setup(bad[j]);
            wr(ADDR_TRIG, 12'h001);
            repeat (4) @(posedge clock);
            rd(ADDR_STATUS, rdata);
            chk("prohibited", 32'h4, {28'h0, rdata[3:0]});
        end
        $display("prohibited test done");
        setup(12'h034);
        trigger(1'b0);
        waitDone(n);
        rd(ADDR_STATUS, rdata);
        chk("done flag", 32'h1, {31'h0, rdata[STAT_DONE]});
        wr(ADDR_STATUS, 12'h002);
        rd(ADDR_STATUS, rdata);
        chk("done cleared", 32'h0, {31'h0, rdata[STAT_DONE]});
        // Second one-shot without a halt has no start delay
        trigger(1'b0);
        waitDone(n);
        rd(ADDR_TIME, rdata);
        chk("later time", {22'h0, NM2_SEL_CYC}, rdata);
        $display("later conversion done");
        trigger(1'b0);
        repeat (20) @(posedge clock);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        chk("busy after reset", 32'h0, {31'h0, convBusy});
        rd(ADDR_CTRL, rdata);
        chk("ctrl after reset", {20'h0, CTRL_RESET}, rdata);
        rd(ADDR_TIME, rdata);
        chk("time after reset", 32'h0, rdata);
        $display("reset test done");
        summarize();
    end
endmodule
